// file: pkg/rod_defines.svh
// constants for the registered one-of-eight decoder
`ifndef ROD_DEFINES_SVH
`define ROD_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ROD_SEL_W          3
`define ROD_OUT_N          8
`define ROD_PIN_N          10

// ----------------------------------------------------------------
// bit positions inside the sampled pin vector
// ----------------------------------------------------------------
`define ROD_PIN_STROBE     0
`define ROD_PIN_LOAD_EN_N  1
`define ROD_PIN_CLEAR_N    2
`define ROD_PIN_LEVEL      3
`define ROD_PIN_SEL_LO     4
`define ROD_PIN_GATE_LO    7
`define ROD_PIN_GATE_HI    8
`define ROD_PIN_OE_N       9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
// active-low enables and clear idle high, everything else idles low
`define ROD_PIN_RST        10'h206
`define ROD_SEL_RST        3'h0
`define ROD_LEVEL_RST      1'h0
`define ROD_Y_RST          8'h00
`define ROD_OE_N_IDLE      8'hff
`define ROD_OE_N_DRIVE     8'h00
`define ROD_ONE            8'h01

`endif

// file: pkg/rod_pkg.sv
// types and decode function for the registered one-of-eight decoder
`include "rod_defines.svh"

package rod_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [`ROD_SEL_W-1:0] rod_sel_t;
  typedef logic [`ROD_OUT_N-1:0] rod_out_t;
  typedef logic [`ROD_PIN_N-1:0] rod_pin_t;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one-hot mask of the selected output
  function automatic rod_out_t rod_mask(input rod_sel_t code);
    rod_mask = rod_out_t'(`ROD_ONE) << code;
  endfunction : rod_mask

  // full output pattern: selected is gate xnor level, others sit at ~level
  function automatic rod_out_t rod_decode(input rod_sel_t code,
                                          input logic     level,
                                          input logic     gate);
    rod_out_t m;
    m = rod_mask(code);
    rod_decode = (m & {`ROD_OUT_N{~(gate ^ level)}}) | (~m & {`ROD_OUT_N{~level}});
  endfunction : rod_decode

endpackage : rod_pkg

// file: design/rod_out_drv.sv
// output stage: decoded pin levels and their drive enables
`timescale 1ns/1ps
`default_nettype none
`include "rod_defines.svh"

module rod_out_drv (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // stored control
  input  wire rod_pkg::rod_sel_t stored_select_bits,
  input  wire logic             stored_level_bit,
  // gating and enable
  input  wire logic             gate_term,
  input  wire logic             output_enable_n,
  // output pins
  output var  rod_pkg::rod_out_t decoded_outputs,
  output var  rod_pkg::rod_out_t decoded_oe_n
);
  import rod_pkg::*;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  rod_out_t y_r;
  rod_out_t oe_n_r;

  // decoded levels, kept running even while floated
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      y_r <= `ROD_Y_RST;
    end else if (clk_en) begin
      y_r <= rod_decode(stored_select_bits, stored_level_bit, gate_term);
    end
  end

  // drive enables: only the buffers see the enable, nothing else does
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_n_r <= `ROD_OE_N_IDLE;
    end else if (clk_en) begin
      oe_n_r <= output_enable_n ? `ROD_OE_N_IDLE : `ROD_OE_N_DRIVE;
    end
  end

  assign decoded_outputs = y_r;
  assign decoded_oe_n    = oe_n_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rod_out_t sel_mask;
  assign sel_mask = rod_mask(stored_select_bits);

  property p_sel_index;
    clk_en && gate_term |=> y_r[$past(stored_select_bits)] == $past(stored_level_bit);
  endproperty
  a_sel_index: assert property (p_sel_index) else $error("selected output wrong");

  property p_unselected;
    clk_en |=> ((y_r ^ {`ROD_OUT_N{~$past(stored_level_bit)}}) & ~$past(sel_mask))
               == `ROD_Y_RST;
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected level wrong");

  property p_sel_follow;
    clk_en |=> y_r[$past(stored_select_bits)]
               == ($past(stored_level_bit) ? $past(gate_term) : !$past(gate_term));
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("gate not followed");

  property p_float;
    clk_en ##1 clk_en |=> decoded_oe_n == {`ROD_OUT_N{$past(output_enable_n)}};
  endproperty
  a_float: assert property (p_float) else $error("drive enable wrong");

  c_float_then_drive: cover property (output_enable_n ##1 !output_enable_n[*2]);
  c_top_output: cover property (clk_en && stored_select_bits == 3'h7 && gate_term);

endmodule : rod_out_drv
`default_nettype wire

// file: design/rod_decoder.sv
// registered one-of-eight decoder with level select and three-state outputs
`timescale 1ns/1ps
`default_nettype none
`include "rod_defines.svh"

module rod_decoder (
  // clock, reset and freeze
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // control register pins
  input  wire logic             register_clear_n,
  input  wire logic             load_strobe,
  input  wire logic             load_enable_n,
  input  wire rod_pkg::rod_sel_t select_code,
  input  wire logic             active_level_select,
  // gating pins
  input  wire logic             gate_low_input,
  input  wire logic             gate_high_input,
  input  wire logic             output_enable_n,
  // three-state outputs
  output var  rod_pkg::rod_out_t decoded_outputs,
  output var  rod_pkg::rod_out_t decoded_oe_n,
  // stored state
  output var  rod_pkg::rod_sel_t stored_select_bits,
  output var  logic             stored_level_bit
);
  import rod_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rod_pin_t pin_raw;
  rod_pin_t pin_s1_r;
  rod_pin_t pin_s2_r;
  rod_pin_t pin_s3_r;
  rod_pin_t pin_f_r;
  rod_pin_t pin_f_nxt;
  rod_pin_t pin_diff;

  assign pin_raw = {output_enable_n, gate_high_input, gate_low_input, select_code,
                    active_level_select, register_clear_n, load_enable_n, load_strobe};

  // three stages; stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_r <= `ROD_PIN_RST;
      pin_s2_r <= `ROD_PIN_RST;
      pin_s3_r <= `ROD_PIN_RST;
    end else if (clk_en) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // a bit only changes once stages two and three agree, which rejects
  // single-cycle glitches at the cost of one extra cycle of latency
  always_comb begin
    pin_diff  = pin_s2_r ^ pin_s3_r;
    pin_f_nxt = (pin_s3_r & ~pin_diff) | (pin_f_r & pin_diff);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_f_r <= `ROD_PIN_RST;
    end else if (clk_en) begin
      pin_f_r <= pin_f_nxt;
    end
  end

  // ----------------------------------------------------------------
  // filtered control levels
  // ----------------------------------------------------------------
  logic     clear_n_f;
  logic     load_en_n_f;
  logic     level_f;
  rod_sel_t sel_f;
  logic     oe_n_f;
  logic     strobe_rise;
  logic     gate_term;

  assign clear_n_f   = pin_f_r[`ROD_PIN_CLEAR_N];
  assign load_en_n_f = pin_f_r[`ROD_PIN_LOAD_EN_N];
  assign level_f     = pin_f_r[`ROD_PIN_LEVEL];
  assign sel_f       = pin_f_r[`ROD_PIN_SEL_LO +: `ROD_SEL_W];
  assign oe_n_f      = pin_f_r[`ROD_PIN_OE_N];

  // low-to-high strobe seen in the cycle the filter accepts it
  assign strobe_rise = pin_f_nxt[`ROD_PIN_STROBE] & ~pin_f_r[`ROD_PIN_STROBE];

  // gate term, usable as data or as an enable for the selected pin
  assign gate_term = ~pin_f_r[`ROD_PIN_GATE_LO] & pin_f_r[`ROD_PIN_GATE_HI];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  rod_sel_t sel_r;
  rod_sel_t sel_nxt;
  logic     level_r;
  logic     level_nxt;
  logic     load_go;

  // data uses the already-filtered levels, so it must settle before the strobe;
  // the system keeps load enable high except for a wanted load
  assign load_go = strobe_rise & ~load_en_n_f;

  // clear wins over any load in the same cycle
  always_comb begin
    sel_nxt   = sel_r;
    level_nxt = level_r;
    if (!clear_n_f) begin
      sel_nxt   = `ROD_SEL_RST;
      level_nxt = `ROD_LEVEL_RST;
    end else if (load_go) begin
      sel_nxt   = sel_f;
      level_nxt = level_f;
    end
  end

  // output enable is deliberately absent from this process
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_r   <= `ROD_SEL_RST;
      level_r <= `ROD_LEVEL_RST;
    end else if (clk_en) begin
      sel_r   <= sel_nxt;
      level_r <= level_nxt;
    end
  end

  assign stored_select_bits = sel_r;
  assign stored_level_bit   = level_r;

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  rod_out_drv u_out (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .clk_en             (clk_en),
    .stored_select_bits (sel_r),
    .stored_level_bit   (level_r),
    .gate_term          (gate_term),
    .output_enable_n    (oe_n_f),
    .decoded_outputs    (decoded_outputs),
    .decoded_oe_n       (decoded_oe_n)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_clear;
    clk_en && !clear_n_f |=> sel_r == `ROD_SEL_RST && !level_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero register");

  property p_load;
    clk_en && clear_n_f && strobe_rise && !load_en_n_f
      |=> sel_r == $past(sel_f) && level_r == $past(level_f);
  endproperty
  a_load: assert property (p_load) else $error("strobe did not load");

  // a strobe pin held low then high raises strobe_rise within four cycles
  property p_strobe_path;
    clk_en[*4] ##0 $rose(pin_s3_r[`ROD_PIN_STROBE]) && pin_s2_r[`ROD_PIN_STROBE]
      && !pin_f_r[`ROD_PIN_STROBE] |-> strobe_rise;
  endproperty
  a_strobe_path: assert property (p_strobe_path) else $error("strobe edge missed");

  property p_hold;
    clk_en && clear_n_f && load_en_n_f |=> $stable(sel_r) && $stable(level_r);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed while held");

  property p_no_load_without_edge;
    clk_en && clear_n_f && !strobe_rise |=> $stable(sel_r) && $stable(level_r);
  endproperty
  a_no_load_without_edge: assert property (p_no_load_without_edge)
    else $error("register changed without strobe");

  property p_gate_out;
    clk_en && level_r |=> decoded_outputs[$past(sel_r)]
      == ($past(!pin_f_r[`ROD_PIN_GATE_LO]) && $past(pin_f_r[`ROD_PIN_GATE_HI]));
  endproperty
  a_gate_out: assert property (p_gate_out) else $error("gate term wrong");

  property p_oe_isolated;
    clk_en && $changed(oe_n_f) && !(load_go && clear_n_f) && clear_n_f
      |=> $stable(sel_r) && $stable(level_r);
  endproperty
  a_oe_isolated: assert property (p_oe_isolated) else $error("enable disturbed register");

  // with the gate open exactly one pin departs from the idle level
  property p_one_of_eight;
    clk_en && gate_term
      |=> (decoded_outputs ^ {`ROD_OUT_N{~$past(level_r)}}) == rod_mask($past(sel_r));
  endproperty
  a_one_of_eight: assert property (p_one_of_eight) else $error("not one of eight");

  // with the gate shut every pin sits at the idle level
  property p_gate_shut;
    clk_en && !gate_term
      |=> (decoded_outputs ^ {`ROD_OUT_N{~$past(level_r)}}) == `ROD_Y_RST;
  endproperty
  a_gate_shut: assert property (p_gate_shut) else $error("gate shut but pin moved");

  c_load: cover property (clk_en && clear_n_f && load_go ##1 sel_r == 3'h7 && level_r);
  c_clear_after_load: cover property (load_go ##[1:8] !clear_n_f ##1 sel_r == 3'h0);
  c_held_strobe: cover property (strobe_rise && load_en_n_f && clear_n_f);

endmodule : rod_decoder
`default_nettype wire

// file: bench/rod_sys_model.sv
// system-side pin driver facing the registered decoder
`timescale 1ns/1ps
`default_nettype none

module rod_sys_model (
  // clock
  input  wire logic              ref_clk,
  // decoder pins
  output var  logic              register_clear_n,
  output var  logic              load_strobe,
  output var  logic              load_enable_n,
  output var  rod_pkg::rod_sel_t select_code,
  output var  logic              active_level_select,
  output var  logic              gate_low_input,
  output var  logic              gate_high_input,
  output var  logic              output_enable_n
);
  import rod_pkg::*;

  // idle levels from time zero
  initial begin
    {register_clear_n, load_enable_n, output_enable_n} = 3'h7;
    {load_strobe, active_level_select, gate_low_input, gate_high_input} = 4'h0;
    select_code = 3'h0;
  end

  // pins move only on falling edges, well clear of sampling
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // setup two cycles, strobe high three, hold four before release
  task automatic load(input rod_sel_t s, input logic l, input logic en_n);
    idle(1);
    select_code = s;
    active_level_select = l;
    load_enable_n = en_n;
    idle(2);
    load_strobe = 1'b1;
    idle(3);
    load_strobe = 1'b0;
    idle(4);
    load_enable_n = 1'b1;
    idle(4);
  endtask : load

  task automatic set_gate(input logic gl, input logic gh);
    idle(1);
    gate_low_input = gl;
    gate_high_input = gh;
  endtask : set_gate

  task automatic set_ctl(input logic clr_n, input logic oe_n);
    idle(1);
    register_clear_n = clr_n;
    output_enable_n = oe_n;
  endtask : set_ctl
endmodule : rod_sys_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the registered one-of-eight decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top;
  import rod_pkg::*;
  typedef struct {rod_sel_t s; logic l; rod_out_t y; rod_out_t oe;} rod_exp_t;
  logic     ref_clk;
  logic     rst_n;
  logic     ce;
  logic     clr_n, strobe, le_n, lvl, gl, gh, oe_n, st_lvl;
  rod_sel_t sel, st_sel;
  rod_out_t y, y_oe_n;
  logic [31:0] r;
  int       n_errors, cmp_count, cycles;
  int       seed = 32'h5256_1012;
  rod_exp_t exp_q[$];
  event     note_ev;

  // ----------------------------------------------------------------
  // clock, parts and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  rod_sys_model m (.ref_clk(ref_clk), .register_clear_n(clr_n), .load_strobe(strobe),
    .load_enable_n(le_n), .select_code(sel), .active_level_select(lvl),
    .gate_low_input(gl), .gate_high_input(gh), .output_enable_n(oe_n));

  // freeze input driven so that a load pulse during a freeze can be checked
  rod_decoder rod_decoder_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce),
    .register_clear_n(clr_n), .load_strobe(strobe), .load_enable_n(le_n),
    .select_code(sel), .active_level_select(lvl), .gate_low_input(gl),
    .gate_high_input(gh), .output_enable_n(oe_n), .decoded_outputs(y),
    .decoded_oe_n(y_oe_n), .stored_select_bits(st_sel), .stored_level_bit(st_lvl));

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // expectations and monitor
  // ----------------------------------------------------------------
  function automatic rod_out_t exp_y(input rod_sel_t s, input logic l, input logic g);
    rod_out_t v;
    v = {8{~l}};
    v[s] = l ? g : ~g;
    return v;
  endfunction : exp_y

  // waits out synchroniser latency with margin, then posts a note
  task automatic note(input rod_sel_t s, input logic l, input logic g, input logic o);
    rod_exp_t e;
    repeat (8) @(negedge ref_clk);
    e.s = s;
    e.l = l;
    e.y = exp_y(s, l, g);
    e.oe = {8{o}};
    exp_q.push_back(e);
    -> note_ev;
  endtask : note

  // oldest note against the settled outputs
  always @(note_ev) begin
    rod_exp_t e;
    e = exp_q.pop_front();
    `CHK(st_sel, e.s)
    `CHK(st_lvl, e.l)
    `CHK(y, e.y)
    `CHK(y_oe_n, e.oe)
  end

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    note(3'h0, 1'b0, 1'b0, 1'b1);
    m.set_ctl(1'b1, 1'b0);
    // every code at both levels, all four gate combinations
    for (int k = 0; k < 16; k++) begin
      m.load(k[2:0], k[3], 1'b0);
      for (int gi = 0; gi < 4; gi++) begin
        m.set_gate(~gi[0], gi[1]);
        note(k[2:0], k[3], gi[0] & gi[1], 1'b0);
      end
      `CHK(y ^ {8{~k[3]}}, rod_out_t'(8'h01) << k[2:0])
    end
    // strobe with load blocked leaves the register alone
    m.load(3'h5, 1'b1, 1'b0);
    m.load(3'h2, 1'b0, 1'b1);
    note(3'h5, 1'b1, 1'b1, 1'b0);
    `CHK(st_sel, 3'h5)
    // floating outputs keeps stored state
    m.set_ctl(1'b1, 1'b1);
    note(3'h5, 1'b1, 1'b1, 1'b1);
    `CHK(st_sel, 3'h5)
    m.set_ctl(1'b1, 1'b0);
    // clear wins over a load in progress
    m.set_ctl(1'b0, 1'b0);
    m.load(3'h6, 1'b1, 1'b0);
    note(3'h0, 1'b0, 1'b1, 1'b0);
    `CHK(st_lvl, 1'b0)
    m.set_ctl(1'b1, 1'b0);
    repeat (8) begin
      r = $random(seed);
      m.load(r[2:0], r[3], 1'b0);
      m.set_gate(r[4], r[5]);
      note(r[2:0], r[3], ~r[4] & r[5], 1'b0);
    end
    // frozen clock enable: a whole load pulse passes unseen
    ce = 1'b0;
    m.load(~r[2:0], ~r[3], 1'b0);
    ce = 1'b1;
    note(r[2:0], r[3], ~r[4] & r[5], 1'b0);
    `CHK(st_sel, r[2:0])
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
